// File: core/tws_defs.svh
// register offsets, reset values and timing counts of the two-wire slave
// assumes: included by bare name from the package and the top module
`ifndef TWS_DEFS_SVH
`define TWS_DEFS_SVH

`define TWS_APB_AW 12
`define TWS_CNT_W 14
`define TWS_ADR_W 7

`define TWS_OFF_PREP_RX 12'h020
`define TWS_OFF_PREP_TX 12'h024
`define TWS_OFF_MATCH 12'h4d4
`define TWS_OFF_RX_PTR 12'h534
`define TWS_OFF_RX_MAX 12'h538
`define TWS_OFF_RX_AMT 12'h53c
`define TWS_OFF_RX_LIST 12'h540
`define TWS_OFF_TX_PTR 12'h544
`define TWS_OFF_TX_MAX 12'h548
`define TWS_OFF_TX_AMT 12'h54c
`define TWS_OFF_TX_LIST 12'h550
`define TWS_OFF_ADR0 12'h588
`define TWS_OFF_ADR1 12'h58c
`define TWS_OFF_CONFIG 12'h594
`define TWS_OFF_ORC 12'h5c0
`define TWS_OFF_STATUS 12'h5fc

`define TWS_LIST_ARRAY 2'h1
`define TWS_RST_STATE '0
`define TWS_SYNC_RST 2'h3

`define TWS_CLK_MHZ 25
`define TWS_PREP_NS 1500
`define TWS_PREP_CYC ((`TWS_PREP_NS * `TWS_CLK_MHZ) / 1000)

`endif

// File: core/tws_pkg.sv
// types shared by the two-wire slave modules
// assumes: tws_defs.svh on the include path
package tws_pkg;
   `include "tws_defs.svh"

   typedef enum logic [2:0] {
      LS_IDLE,
      LS_ADDR,
      LS_ADDR_ACK,
      LS_RX_BYTE,
      LS_RX_ACK,
      LS_TX_BYTE,
      LS_TX_ACK
   } tws_lst_t;

   typedef struct packed {
      logic [31:0] rx_ptr;
      logic [`TWS_CNT_W-1:0] rx_max;
      logic [`TWS_CNT_W-1:0] rx_amt;
      logic [1:0] rx_list;
      logic [31:0] tx_ptr;
      logic [`TWS_CNT_W-1:0] tx_max;
      logic [`TWS_CNT_W-1:0] tx_amt;
      logic [1:0] tx_list;
      logic [`TWS_ADR_W-1:0] adr0;
      logic [`TWS_ADR_W-1:0] adr1;
      logic [1:0] cfg;
      logic [7:0] overread_fill_char;
      logic match;
      logic [5:0] rx_tmr;
      logic [5:0] tx_tmr;
      logic rx_rdy;
      logic tx_rdy;
      logic scl_p;
      logic sda_p;
      tws_lst_t st;
      logic [3:0] bitcnt;
      logic [7:0] sh;
      logic rw;
      logic active;
      logic nack;
      logic sda_oe;
      logic [`TWS_CNT_W-1:0] rx_cnt;
      logic [`TWS_CNT_W-1:0] tx_cnt;
      logic [7:0] tx_data;
      logic mem_req;
      logic mem_we;
      logic [31:0] mem_addr;
      logic [7:0] mem_wdata;
      logic [31:0] prdata;
   } tws_state_t;
endpackage

// File: core/tws_match_if.sv
// carries the 7-bit address and slot setup to the matcher and its verdict back
// assumes: one requester and one matcher on the same clock
`timescale 1ns/100ps
interface tws_match_if;
   logic clk;
   logic [6:0] addr;
   logic [1:0][6:0] slot;
   logic [1:0] en;
   logic hit;
   logic idx;
   modport req (output clk, output addr, output slot, output en,
      input hit, input idx);
   modport mat (input clk, input addr, input slot, input en,
      output hit, output idx);
endinterface

// File: core/tws_sync.sv
// two-flop synchroniser for pin levels
// assumes: inputs asynchronous to clk_i, reset already synchronised
`timescale 1ns/100ps
module tws_sync #(
   parameter int W = 2,
   parameter logic [W-1:0] RST = '1
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } tws_sync_t;
   tws_sync_t s_q, s_d;

   always_comb begin
      s_d.s1 = d_i;
      s_d.s2 = s_q.s1;
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_q <= {RST, RST};
      end else begin
         s_q <= s_d;
      end
   end

   assign q_o = s_q.s2;
endmodule // tws_sync

// File: core/tws_addr_match.sv
// compares a bus address against the enabled slave-address slots
// assumes: slot 0 wins when both slots hold the same address
`timescale 1ns/100ps
module tws_addr_match (
   tws_match_if.mat m
);
   logic [1:0] eq;

   genvar i;
   generate
      for (i = 0; i < 2; i++) begin : g_slot
         assign eq[i] = m.en[i] && (m.slot[i] == m.addr);
      end
   endgenerate

   assign m.hit = |eq;
   assign m.idx = ~eq[0] & eq[1];

   a_hit_slot: assert property (@(posedge m.clk)
      m.hit |-> m.en[m.idx] && m.slot[m.idx] == m.addr &&
         !(m.idx && m.en[0] && m.slot[0] == m.addr))
      else $error("match hit on a slot that does not match");
endmodule // tws_addr_match

// File: core/tws_top.sv
// two-wire slave with memory access: APB registers, bus engine, buffers
// assumes: APB on clk_i, scl/sda from pins, memory port on clk_i
`timescale 1ns/100ps
`include "tws_defs.svh"
module tws_top (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [`TWS_APB_AW-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   output logic mem_req_o,
   output logic mem_we_o,
   output logic [31:0] mem_addr_o,
   output logic [7:0] mem_wdata_o,
   input wire logic [7:0] mem_rdata_i,
   input wire logic mem_ack_i
);
   localparam int PREP_C = `TWS_PREP_CYC;
   localparam logic [5:0] PREP_LD = 6'(`TWS_PREP_CYC);
   // pins idle high: edge detectors start from that level, no false edge
   localparam tws_pkg::tws_state_t RST_S = '{scl_p: 1'b1, sda_p: 1'b1,
      st: tws_pkg::LS_IDLE, default: `TWS_RST_STATE};

   logic [1:0] rst_q;
   logic rst_n;
   logic scl_s, sda_s;
   logic scl_rise, scl_fall, start_c, stop_c;
   logic apb_setup, apb_wr;
   tws_pkg::tws_state_t s_q, s_d;
   tws_match_if mif ();

   // release of the async reset through two flops
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_q <= 2'h0;
      end else begin
         rst_q <= {rst_q[0], 1'b1};
      end
   end
   assign rst_n = rst_q[1];

   tws_sync #(.W(2), .RST(`TWS_SYNC_RST)) u_sync (
      .clk_i(clk_i),
      .rst_n_i(rst_n),
      .d_i({scl_i, sda_i}),
      .q_o({scl_s, sda_s})
   );

   tws_addr_match u_match (
      .m(mif.mat)
   );

   assign mif.clk = clk_i;
   assign mif.addr = s_q.sh[7:1];
   assign mif.slot = {s_q.adr1, s_q.adr0};
   assign mif.en = s_q.cfg;

   assign scl_rise = scl_s & ~s_q.scl_p;
   assign scl_fall = ~scl_s & s_q.scl_p;
   assign start_c = scl_s & s_q.scl_p & s_q.sda_p & ~sda_s;
   assign stop_c = scl_s & s_q.scl_p & ~s_q.sda_p & sda_s;
   assign apb_setup = psel_i & ~penable_i;
   assign apb_wr = psel_i & penable_i & pwrite_i;

   function automatic logic mapped(input logic [`TWS_APB_AW-1:0] a);
      case (a)
         `TWS_OFF_PREP_RX, `TWS_OFF_PREP_TX, `TWS_OFF_MATCH,
         `TWS_OFF_RX_PTR, `TWS_OFF_RX_MAX, `TWS_OFF_RX_AMT,
         `TWS_OFF_RX_LIST, `TWS_OFF_TX_PTR, `TWS_OFF_TX_MAX,
         `TWS_OFF_TX_AMT, `TWS_OFF_TX_LIST, `TWS_OFF_ADR0,
         `TWS_OFF_ADR1, `TWS_OFF_CONFIG, `TWS_OFF_ORC,
         `TWS_OFF_STATUS: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   endfunction

   function automatic logic [31:0] rd_word(
      input tws_pkg::tws_state_t s,
      input logic [`TWS_APB_AW-1:0] a
   );
      case (a)
         `TWS_OFF_MATCH: rd_word = {31'h0, s.match};
         `TWS_OFF_RX_PTR: rd_word = s.rx_ptr;
         `TWS_OFF_RX_MAX: rd_word = {18'h0, s.rx_max};
         `TWS_OFF_RX_AMT: rd_word = {18'h0, s.rx_amt};
         `TWS_OFF_RX_LIST: rd_word = {30'h0, s.rx_list};
         `TWS_OFF_TX_PTR: rd_word = s.tx_ptr;
         `TWS_OFF_TX_MAX: rd_word = {18'h0, s.tx_max};
         `TWS_OFF_TX_AMT: rd_word = {18'h0, s.tx_amt};
         `TWS_OFF_TX_LIST: rd_word = {30'h0, s.tx_list};
         `TWS_OFF_ADR0: rd_word = {25'h0, s.adr0};
         `TWS_OFF_ADR1: rd_word = {25'h0, s.adr1};
         `TWS_OFF_CONFIG: rd_word = {30'h0, s.cfg};
         `TWS_OFF_ORC: rd_word = {24'h0, s.overread_fill_char};
         `TWS_OFF_STATUS: rd_word = {29'h0, s.active, s.tx_rdy, s.rx_rdy};
         default: rd_word = 32'h0;
      endcase
   endfunction

   always_comb begin
      logic [7:0] nxt;
      logic [`TWS_CNT_W-1:0] ncnt;
      nxt = 8'h00;
      ncnt = '0;
      s_d = s_q;
      s_d.scl_p = scl_s;
      s_d.sda_p = sda_s;

      // prepare tasks arm a countdown; ready follows when it expires
      if (s_q.rx_tmr != 6'h00) begin
         s_d.rx_tmr = s_q.rx_tmr - 6'h01;
         if (s_q.rx_tmr == 6'h01) begin
            s_d.rx_rdy = 1'b1;
         end
      end
      if (s_q.tx_tmr != 6'h00) begin
         s_d.tx_tmr = s_q.tx_tmr - 6'h01;
         if (s_q.tx_tmr == 6'h01) begin
            s_d.tx_rdy = 1'b1;
         end
      end

      // read data is latched in the setup phase, so prdata is a flop
      if (apb_setup) begin
         s_d.prdata = rd_word(s_q, paddr_i);
      end
      if (apb_wr) begin
         case (paddr_i)
            `TWS_OFF_PREP_RX: begin
               if (pwdata_i[0]) begin
                  s_d.rx_tmr = PREP_LD;
                  s_d.rx_rdy = 1'b0;
               end
            end
            `TWS_OFF_PREP_TX: begin
               if (pwdata_i[0]) begin
                  s_d.tx_tmr = PREP_LD;
                  s_d.tx_rdy = 1'b0;
               end
            end
            `TWS_OFF_RX_PTR: s_d.rx_ptr = pwdata_i;
            `TWS_OFF_RX_MAX: s_d.rx_max = pwdata_i[`TWS_CNT_W-1:0];
            `TWS_OFF_RX_LIST: s_d.rx_list = pwdata_i[1:0];
            `TWS_OFF_TX_PTR: s_d.tx_ptr = pwdata_i;
            `TWS_OFF_TX_MAX: s_d.tx_max = pwdata_i[`TWS_CNT_W-1:0];
            `TWS_OFF_TX_LIST: s_d.tx_list = pwdata_i[1:0];
            `TWS_OFF_ADR0: s_d.adr0 = pwdata_i[6:0];
            `TWS_OFF_ADR1: s_d.adr1 = pwdata_i[6:0];
            `TWS_OFF_CONFIG: s_d.cfg = pwdata_i[1:0];
            `TWS_OFF_ORC: s_d.overread_fill_char = pwdata_i[7:0];
            default: ;
         endcase
      end

      if (s_q.mem_req && mem_ack_i) begin
         s_d.mem_req = 1'b0;
         if (!s_q.mem_we) begin
            s_d.tx_data = mem_rdata_i;
         end
      end

      // next byte out: buffer while it lasts, then the fill character
      if (s_q.tx_cnt < s_q.tx_max) begin
         nxt = s_q.tx_data;
      end else begin
         nxt = s_q.overread_fill_char;
      end
      ncnt = s_q.tx_cnt + 1'b1;

      if (start_c || stop_c) begin
         if (s_q.active) begin
            if (s_q.rw) begin
               s_d.tx_amt = s_q.tx_cnt;
               s_d.tx_rdy = 1'b0;
               if (s_q.tx_list == `TWS_LIST_ARRAY) begin
                  s_d.tx_ptr = s_q.tx_ptr + {18'h0, s_q.tx_max};
               end
            end else begin
               s_d.rx_amt = s_q.rx_cnt;
               s_d.rx_rdy = 1'b0;
               if (s_q.rx_list == `TWS_LIST_ARRAY) begin
                  s_d.rx_ptr = s_q.rx_ptr + {18'h0, s_q.rx_max};
               end
            end
         end
         s_d.active = 1'b0;
         s_d.sda_oe = 1'b0;
         s_d.bitcnt = 4'h0;
         s_d.st = start_c ? tws_pkg::LS_ADDR : tws_pkg::LS_IDLE;
      end else begin
         case (s_q.st)
            tws_pkg::LS_IDLE: ;
            tws_pkg::LS_ADDR: begin
               if (scl_rise) begin
                  s_d.sh = {s_q.sh[6:0], sda_s};
                  s_d.bitcnt = s_q.bitcnt + 4'h1;
               end else if (scl_fall && s_q.bitcnt == 4'h8) begin
                  // not ready or no slot hit: leave sda released
                  if (mif.hit && (s_q.sh[0] ? s_q.tx_rdy : s_q.rx_rdy)) begin
                     s_d.st = tws_pkg::LS_ADDR_ACK;
                     s_d.sda_oe = 1'b1;
                     s_d.match = mif.idx;
                     s_d.rw = s_q.sh[0];
                     s_d.active = 1'b1;
                     s_d.rx_cnt = '0;
                     s_d.tx_cnt = '0;
                     if (s_q.sh[0] && s_q.tx_max != '0) begin
                        s_d.mem_req = 1'b1;
                        s_d.mem_we = 1'b0;
                        s_d.mem_addr = s_q.tx_ptr;
                     end
                  end else begin
                     s_d.st = tws_pkg::LS_IDLE;
                  end
               end
            end
            tws_pkg::LS_ADDR_ACK, tws_pkg::LS_TX_ACK: begin
               if (scl_rise) begin
                  s_d.nack = sda_s;
               end else if (scl_fall) begin
                  s_d.bitcnt = 4'h0;
                  s_d.sda_oe = 1'b0;
                  if (!s_q.rw) begin
                     s_d.st = tws_pkg::LS_RX_BYTE;
                  end else if (s_q.st == tws_pkg::LS_TX_ACK && s_q.nack) begin
                     s_d.st = tws_pkg::LS_IDLE;
                  end else begin
                     s_d.st = tws_pkg::LS_TX_BYTE;
                     s_d.sh = nxt;
                     s_d.sda_oe = ~nxt[7];
                     if (s_q.tx_cnt < s_q.tx_max) begin
                        s_d.tx_cnt = ncnt;
                        if (ncnt < s_q.tx_max) begin
                           s_d.mem_req = 1'b1;
                           s_d.mem_we = 1'b0;
                           s_d.mem_addr = s_q.tx_ptr + {18'h0, ncnt};
                        end
                     end
                  end
               end
            end
            tws_pkg::LS_TX_BYTE: begin
               if (scl_fall) begin
                  if (s_q.bitcnt == 4'h7) begin
                     s_d.sda_oe = 1'b0;
                     s_d.st = tws_pkg::LS_TX_ACK;
                  end else begin
                     s_d.sh = {s_q.sh[6:0], 1'b0};
                     s_d.sda_oe = ~s_q.sh[6];
                     s_d.bitcnt = s_q.bitcnt + 4'h1;
                  end
               end
            end
            tws_pkg::LS_RX_BYTE: begin
               if (scl_rise) begin
                  s_d.sh = {s_q.sh[6:0], sda_s};
                  s_d.bitcnt = s_q.bitcnt + 4'h1;
               end else if (scl_fall && s_q.bitcnt == 4'h8) begin
                  s_d.st = tws_pkg::LS_RX_ACK;
                  // full buffer: byte dropped and answered with a nack
                  if (s_q.rx_cnt < s_q.rx_max) begin
                     s_d.mem_req = 1'b1;
                     s_d.mem_we = 1'b1;
                     s_d.mem_addr = s_q.rx_ptr + {18'h0, s_q.rx_cnt};
                     s_d.mem_wdata = s_q.sh;
                     s_d.rx_cnt = s_q.rx_cnt + 1'b1;
                     s_d.sda_oe = 1'b1;
                  end
               end
            end
            tws_pkg::LS_RX_ACK: begin
               if (scl_fall) begin
                  s_d.sda_oe = 1'b0;
                  s_d.bitcnt = 4'h0;
                  s_d.st = tws_pkg::LS_RX_BYTE;
               end
            end
            default: s_d.st = tws_pkg::LS_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= RST_S;
      end else begin
         s_q <= s_d;
      end
   end

   assign prdata_o = s_q.prdata;
   assign pready_o = 1'b1;
   assign pslverr_o = psel_i & penable_i & ~mapped(paddr_i);
   assign sda_o = 1'b0;
   assign sda_oe_o = s_q.sda_oe;
   assign mem_req_o = s_q.mem_req;
   assign mem_we_o = s_q.mem_we;
   assign mem_addr_o = s_q.mem_addr;
   assign mem_wdata_o = s_q.mem_wdata;

   default clocking cb_main @(posedge clk_i);
   endclocking
   default disable iff (!rst_n);
   a_rx_store_cap: assert property (
      $rose(mem_req_o) && mem_we_o |->
         mem_addr_o - s_q.rx_ptr < {18'h0, s_q.rx_max})
      else $error("receive write beyond the rx maximum");
   a_tx_fetch_cap: assert property (
      $rose(mem_req_o) && !mem_we_o |->
         mem_addr_o - s_q.tx_ptr < {18'h0, s_q.tx_max})
      else $error("transmit fetch beyond the tx maximum");
   a_prep_rx_time: assert property (
      apb_wr && paddr_i == `TWS_OFF_PREP_RX && pwdata_i[0] |=>
         !s_q.rx_rdy ##PREP_C s_q.rx_rdy)
      else $error("rx ready not on time after prepare");
   a_prep_tx_time: assert property (
      apb_wr && paddr_i == `TWS_OFF_PREP_TX && pwdata_i[0] |=>
         !s_q.tx_rdy ##PREP_C s_q.tx_rdy)
      else $error("tx ready not on time after prepare");
   a_rx_amount: assert property (
      (start_c || stop_c) && s_q.active && !s_q.rw |=>
         s_q.rx_amt == $past(s_q.rx_cnt) && !s_q.active)
      else $error("rx amount not updated at end of transaction");
   a_tx_amount: assert property (
      (start_c || stop_c) && s_q.active && s_q.rw |=>
         s_q.tx_amt == $past(s_q.tx_cnt) && !s_q.tx_rdy)
      else $error("tx amount not updated at end of transaction");
   a_orc_fill: assert property (
      s_q.st == tws_pkg::LS_TX_ACK && scl_fall && !s_q.nack && !start_c &&
         !stop_c && s_q.tx_cnt >= s_q.tx_max |=>
         s_q.sh == s_q.overread_fill_char && s_q.st == tws_pkg::LS_TX_BYTE)
      else $error("over-read byte is not the fill character");
   a_match_index: assert property (
      s_q.st == tws_pkg::LS_ADDR && scl_fall && s_q.bitcnt == 4'h8 &&
         !start_c && !stop_c && mif.hit |=> s_q.match == $past(mif.idx))
      else $error("match field does not name the matching slot");
   a_addr_nack: assert property (
      s_q.st == tws_pkg::LS_ADDR && scl_fall && s_q.bitcnt == 4'h8 &&
         !start_c && !stop_c && !mif.hit |=>
         !sda_oe_o && s_q.st == tws_pkg::LS_IDLE)
      else $error("unmatched address was acknowledged");
endmodule // tws_top

// File: testbench/tws_i2c_master.sv
// behavioural two-wire bus master driving the slave's scl and sda pins
// assumes: sda_i is the resolved open-drain line, pulled up when released
`timescale 1ns/100ps
module tws_i2c_master (
   input wire logic clk_i,
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_oe_o
);
   // scl idles high between frames, as the pull-up leaves it
   initial begin
      scl_o = 1'b1;
      sda_oe_o = 1'b0;
   end

   // quarter bit: two clocks, so one bit lasts 320 ns
   task automatic q();
      repeat (2) @(posedge clk_i);
   endtask

   task automatic clk_bit(input logic b, output logic s);
      sda_oe_o <= ~b;
      q();
      scl_o <= 1'b1;
      q();
      s = sda_i;
      q();
      scl_o <= 1'b0;
      q();
   endtask

   task automatic start();
      sda_oe_o <= 1'b0;
      scl_o <= 1'b1;
      q();
      sda_oe_o <= 1'b1;
      q();
      scl_o <= 1'b0;
      q();
   endtask

   task automatic stop();
      sda_oe_o <= 1'b1;
      q();
      scl_o <= 1'b1;
      q();
      sda_oe_o <= 1'b0;
      q();
   endtask

   task automatic send(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         clk_bit(d[i], s);
      end
      clk_bit(1'b1, s);
      ack = ~s;
   endtask

   task automatic recv(input logic ack, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         clk_bit(1'b1, s);
         d[i] = s;
      end
      clk_bit(~ack, s);
   endtask
endmodule // tws_i2c_master

// File: testbench/tws_top_tb.sv
// self-checking bench: apb register access, bus transfers, memory responder
// assumes: tws_defs.svh on the include path, 25 MHz clock
`timescale 1ns/100ps
`include "tws_defs.svh"
module tws_top_tb;
   logic clk = 1'b0, rst_n = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [`TWS_APB_AW-1:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata_o;
   logic pready_o, pslverr_o, sda_o, sda_oe_o, scl, m_oe, sda_line;
   logic mem_req_o, mem_we_o, mem_ack = 1'b0;
   logic [31:0] mem_addr_o;
   logic [7:0] mem_wdata_o, mem_rdata = 8'h00;
   logic [7:0] mem [256];
   int n_errors = 0, n_compared = 0, n_fetch = 0;

   always #20 clk = ~clk;
   // open-drain line with pull-up
   assign sda_line = ~(m_oe | (sda_oe_o & ~sda_o));

   tws_top dut_u (.clk_i(clk), .rst_n_i(rst_n), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
      .pwdata_i(pwdata), .prdata_o(prdata_o), .pready_o(pready_o),
      .pslverr_o(pslverr_o), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o),
      .sda_oe_o(sda_oe_o), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o),
      .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
      .mem_rdata_i(mem_rdata), .mem_ack_i(mem_ack));
   tws_i2c_master m_u (.clk_i(clk), .sda_i(sda_line), .scl_o(scl),
      .sda_oe_o(m_oe));

   // memory: one-cycle ack; read data scrambled outside the ack cycle
   always @(posedge clk) begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req_o && !mem_ack) begin
         mem_ack <= 1'b1;
         mem_rdata <= mem[mem_addr_o[7:0]];
         if (mem_we_o) begin
            mem[mem_addr_o[7:0]] <= mem_wdata_o;
         end else begin
            n_fetch++;
         end
      end
   end

   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %0t flag %b expected %b", $time, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a,
         input logic [31:0] wd, output logic [31:0] rd, output logic err);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready_o !== 1'b1);
      rd = prdata_o;
      err = pslverr_o;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic e;
      apb(1'b1, a, d, rd, e);
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] rd;
      logic e;
      apb(1'b0, a, '0, rd, e);
      chk32(rd, exp);
      chk1(e, 1'b0);
   endtask

   task automatic conclude();
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      conclude();
   end

   initial begin
      logic [31:0] rd;
      logic e, ack;
      logic [7:0] b;
      for (int i = 0; i < 256; i++) begin
         mem[i] = 8'hee;
      end
      mem[8'h40] = 8'h3c;
      mem[8'h41] = 8'hc7;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      rd_chk(`TWS_OFF_RX_AMT, 32'h0000_0000);
      rd_chk(`TWS_OFF_TX_PTR, 32'h0000_0000);
      rd_chk(`TWS_OFF_MATCH, 32'h0000_0000);
      rd_chk(`TWS_OFF_RX_LIST, 32'h0000_0000);
      chk1(sda_o, 1'b0);
      apb(1'b0, 12'h7f0, '0, rd, e);
      chk1(e, 1'b1);
      wr(`TWS_OFF_TX_PTR, 32'hffff_fff0);
      rd_chk(`TWS_OFF_TX_PTR, 32'hffff_fff0);
      wr(`TWS_OFF_RX_AMT, 32'h0000_0055);
      rd_chk(`TWS_OFF_RX_AMT, 32'h0000_0000);
      // buffers placed in the memory the responder models
      wr(`TWS_OFF_TX_PTR, 32'h0000_0040);
      wr(`TWS_OFF_RX_PTR, 32'h0000_0010);
      // array list on rx: pointer steps by the maximum after the frame
      wr(`TWS_OFF_RX_LIST, 32'h0000_0001);
      wr(`TWS_OFF_RX_MAX, 32'h0000_0002);
      wr(`TWS_OFF_TX_MAX, 32'h0000_0002);
      wr(`TWS_OFF_ADR0, 32'h0000_0021);
      wr(`TWS_OFF_ADR1, 32'h0000_0035);
      wr(`TWS_OFF_CONFIG, 32'h0000_0002);
      wr(`TWS_OFF_ORC, 32'h0000_00a5);
      rd_chk(`TWS_OFF_ORC, 32'h0000_00a5);
      wr(`TWS_OFF_PREP_RX, 32'h0000_0001);
      rd_chk(`TWS_OFF_STATUS, 32'h0000_0000);
      repeat (40) @(posedge clk);
      rd_chk(`TWS_OFF_STATUS, 32'h0000_0001);
      // write to slot 1 one byte past the rx maximum
      m_u.start();
      m_u.send(8'h6a, ack);
      chk1(ack, 1'b1);
      rd_chk(`TWS_OFF_STATUS, 32'h0000_0005);
      m_u.send(8'h11, ack);
      m_u.send(8'h22, ack);
      m_u.send(8'h33, ack);
      chk1(ack, 1'b0);
      m_u.stop();
      repeat (4) @(posedge clk);
      chk32({24'h0, mem[8'h10]}, 32'h0000_0011);
      chk32({24'h0, mem[8'h11]}, 32'h0000_0022);
      chk32({24'h0, mem[8'h12]}, 32'h0000_00ee);
      rd_chk(`TWS_OFF_RX_AMT, 32'h0000_0002);
      rd_chk(`TWS_OFF_MATCH, 32'h0000_0001);
      rd_chk(`TWS_OFF_RX_PTR, 32'h0000_0012);
      // read from slot 0 one byte past the tx buffer
      wr(`TWS_OFF_CONFIG, 32'h0000_0003);
      wr(`TWS_OFF_PREP_TX, 32'h0000_0001);
      repeat (40) @(posedge clk);
      rd_chk(`TWS_OFF_STATUS, 32'h0000_0002);
      m_u.start();
      m_u.send(8'h43, ack);
      chk1(ack, 1'b1);
      m_u.recv(1'b1, b);
      chk32({24'h0, b}, 32'h0000_003c);
      m_u.recv(1'b1, b);
      chk32({24'h0, b}, 32'h0000_00c7);
      m_u.recv(1'b0, b);
      chk32({24'h0, b}, 32'h0000_00a5);
      m_u.stop();
      repeat (4) @(posedge clk);
      chk32(n_fetch, 32'h0000_0002);
      rd_chk(`TWS_OFF_TX_AMT, 32'h0000_0002);
      rd_chk(`TWS_OFF_MATCH, 32'h0000_0000);
      rd_chk(`TWS_OFF_TX_PTR, 32'h0000_0040);
      // slot 1 disabled: its address is not answered
      wr(`TWS_OFF_CONFIG, 32'h0000_0001);
      wr(`TWS_OFF_PREP_RX, 32'h0000_0001);
      repeat (40) @(posedge clk);
      m_u.start();
      m_u.send(8'h6a, ack);
      chk1(ack, 1'b0);
      m_u.stop();
      conclude();
   end
endmodule // tws_top_tb
